// file: cdsr_host_model.sv
`timescale 1ns/1ps
// host side of the register port, one word per access
module cdsr_host_model
  import cdsr_pkg::*;
(
  // clock
  input  wire logic        clk_sys_i,
  // register port
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [7:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i
);
  // idle lines at time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'hFF;
    reg_wdata_o = 16'h0000;
  end
  // write strobe for exactly one taking edge
  task automatic write(input logic [7:0] addr, input logic [15:0] data);
    logic [15:0] d;
    d = data;
    // unsupported threshold codes never leave the host
    if (addr == ADDR_ILIM && d[THR_HI:THR_LO] > THR_MAX) d[THR_HI:THR_LO] = THR_MAX;
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= addr;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b0;
    // released lines must not keep showing the old word
    reg_addr_o  <= ~addr;
    reg_wdata_o <= ~d;
  endtask
  // read strobe, data registered one cycle later
  task automatic read(input logic [7:0] addr, output logic [15:0] data);
    @(posedge clk_sys_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= addr;
    @(posedge clk_sys_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~addr;
    #1;
    data = reg_rdata_i;
  endtask
endmodule

// file: cdsr_pkg.sv
// Overview of operation
// RULE_01 - steady overcurrent threshold from 4-bit select
// RULE_02 - host writes only threshold codes 0h..Ch
// RULE_03 - bit 15 disables voltage sense, resets 1
// RULE_04 - bit 14 disables temperature sense, resets 1
// RULE_05 - bit 13 disables current sense, resets 0
// RULE_06 - on-state open-load threshold stored, no effect
// RULE_07 - bit 10 selects current gain eight
// RULE_08 - bit 9 precise open-load, not under fault
// RULE_09 - bits 8-7 select diagnostic blanking time
// RULE_10 - bits 6-5 select off-state pull-up current
// RULE_11 - bit 4 pull-up check, blocked when on/fault
// RULE_12 - bit 3 battery-short check, blocked when on/fault
// RULE_13 - bit 2 latches off versus auto-retry
// RULE_14 - bits 1-0 select slew, reset 2h
// RULE_15 - current result bits 9-0, upper zero
// RULE_16 - bit 10 flags result fresh since read
// RULE_17 - temperature result bits 9-0, resets zero
// RULE_18 - 3-bit inrush period select sets timing
// RULE_19 - result writes ignored, read clears fresh
package cdsr_pkg;
  // register indices as printed, each one 16-bit word
  localparam logic [7:0]  ADDR_ILIM      = 8'h17;
  localparam logic [7:0]  ADDR_DIAG      = 8'h18;
  localparam logic [7:0]  ADDR_CUR       = 8'h19;
  localparam logic [7:0]  ADDR_TEMP      = 8'h1A;
  // reset values
  localparam logic [15:0] DIAG_RESET     = 16'hC002;
  localparam logic [15:0] ILIM_RESET     = 16'h0088;
  // field positions in the diagnostic word
  localparam int          VSNS_OFF_BIT   = 15;
  localparam int          TSNS_OFF_BIT   = 14;
  localparam int          ISNS_OFF_BIT   = 13;
  localparam int          OLTH_HI        = 12;
  localparam int          OLTH_LO        = 11;
  localparam int          GAIN8_BIT      = 10;
  localparam int          OLPREC_BIT     = 9;
  localparam int          BLANK_HI       = 8;
  localparam int          BLANK_LO       = 7;
  localparam int          PU_HI          = 6;
  localparam int          PU_LO          = 5;
  localparam int          OLOFF_BIT      = 4;
  localparam int          SVBB_BIT       = 3;
  localparam int          LATCH_BIT      = 2;
  localparam int          SLEW_HI        = 1;
  localparam int          SLEW_LO        = 0;
  // fields in the current limit word
  localparam int          INR_HI         = 10;
  localparam int          INR_LO         = 8;
  localparam int          THR_HI         = 3;
  localparam int          THR_LO         = 0;
  localparam logic [3:0]  THR_MAX        = 4'hC;
  // result layout
  localparam int          FRESH_BIT      = 10;
  localparam int          RES_W          = 10;
  // timing: clock and blanking / inrush units
  localparam int          CLK_MHZ        = 200;
  localparam int          TICK_US        = 100;
  localparam int          TICK_CYC       = TICK_US * CLK_MHZ;
  // blanking times in 100 us ticks: 0.4, 1.0, 2.0, 4.0 ms
  localparam logic [15:0] BLANK_TICKS [4] = '{16'h0004, 16'h000A, 16'h0014, 16'h0028};
  // inrush times in 100 us ticks: 0,2,4,6,10,20,50,100 ms
  localparam logic [15:0] INR_TICKS [8] = '{16'h0000, 16'h0014, 16'h0028, 16'h003C,
                                            16'h0064, 16'h00C8, 16'h01F4, 16'h03E8};
  // phases of the channel protection sequencer
  typedef enum logic [1:0] {CDSR_OFF, CDSR_INRUSH, CDSR_STEADY, CDSR_FAULT} cdsr_phase_e;
endpackage

// file: cdsr_regs.sv
`timescale 1ns/1ps
// channel-2 configuration and readback registers with sequencing
module cdsr_regs
  import cdsr_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // register access port from serial front end (same clock)
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // channel state from analog side (asynchronous)
  input  wire logic        chan_on_i,
  input  wire logic        chan_fault_i,
  input  wire logic        current_high_i,
  input  wire logic        switch_state_wr_i,
  // adc results (same clock)
  input  wire logic        cur_conv_i,
  input  wire logic [9:0]  cur_data_i,
  input  wire logic        temp_conv_i,
  input  wire logic [9:0]  temp_data_i,
  // controls to analog side
  output logic [3:0]       overcurrent_threshold_sel_o,
  output logic             inrush_active_o,
  output logic             voltage_sense_off_o,
  output logic             temp_sense_off_o,
  output logic             current_sense_off_o,
  output logic             current_sense_gain8_o,
  output logic             on_openload_precise_en_o,
  output logic [1:0]       off_pullup_strength_o,
  output logic             off_openload_check_en_o,
  output logic             battery_short_check_en_o,
  output logic             diag_blank_done_o,
  output logic             fault_latched_o,
  output logic [1:0]       output_slew_sel_o
);
  logic [15:0] diag_q;        // diagnostic configuration word
  logic [15:0] ilim_q;        // current limit configuration word
  logic [1:0]  on_s_q, flt_s_q, hi_s_q, sw_s_q;  // synchronisers
  logic        sw_prev_q;     // switch-state write edge memory
  logic [15:0] tick_q;        // 100 us prescaler
  logic [15:0] blank_cnt_q;   // blanking tick counter
  logic [15:0] inr_cnt_q;     // inrush tick counter
  logic        latched_q;
  cdsr_phase_e phase_q;
  logic        tick;
  logic        chan_on, chan_flt, cur_hi, sw_edge;
  logic        diag_req;

  cdsr_res_if cur_if ();
  cdsr_res_if temp_if ();

  assign chan_on  = on_s_q[1];
  assign chan_flt = flt_s_q[1];
  assign cur_hi   = hi_s_q[1];
  assign sw_edge  = sw_s_q[1] & ~sw_prev_q;
  assign tick     = (tick_q == 16'(TICK_CYC - 1));
  assign diag_req = diag_q[OLOFF_BIT] | diag_q[SVBB_BIT];

  // two-flop synchronisers for analog status pins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      on_s_q    <= 2'h0;
      flt_s_q   <= 2'h0;
      hi_s_q    <= 2'h0;
      sw_s_q    <= 2'h0;
      sw_prev_q <= 1'b0;
    end else if (ce_i) begin
      on_s_q    <= {on_s_q[0], chan_on_i};
      flt_s_q   <= {flt_s_q[0], chan_fault_i};
      hi_s_q    <= {hi_s_q[0], current_high_i};
      sw_s_q    <= {sw_s_q[0], switch_state_wr_i};
      sw_prev_q <= sw_s_q[1];
    end
  end

  // diagnostic word: writable, off-state check bits refused under on/fault, precise open-load under fault/high current
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag_q <= DIAG_RESET; // RULE_03 RULE_04 RULE_05 RULE_14
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == ADDR_DIAG) begin
        diag_q <= reg_wdata_i; // RULE_06 RULE_07 RULE_09 RULE_10 RULE_13
        // precise open-load is refused on fault or high current
        diag_q[OLPREC_BIT] <= reg_wdata_i[OLPREC_BIT] & ~chan_flt & ~cur_hi; // RULE_08
        diag_q[OLOFF_BIT]  <= reg_wdata_i[OLOFF_BIT] & ~chan_on & ~chan_flt; // RULE_11
        diag_q[SVBB_BIT]   <= reg_wdata_i[SVBB_BIT] & ~chan_on & ~chan_flt;  // RULE_12
      end else if (chan_on || chan_flt) begin
        // off-state checks drop out once the channel turns on or faults
        diag_q[OLOFF_BIT] <= 1'b0; // RULE_11
        diag_q[SVBB_BIT]  <= 1'b0; // RULE_12
      end
    end
  end

  // current limit word; unsupported threshold codes are the host's concern
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ilim_q <= ILIM_RESET; // RULE_01
    end else if (ce_i && reg_wr_i && reg_addr_i == ADDR_ILIM) begin
      ilim_q <= reg_wdata_i; // RULE_02
    end
  end

  // 100 us tick prescaler shared by blanking and inrush timers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_q <= '0;
    end else if (ce_i) begin
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  // protection phase: inrush then steady threshold, fault handling
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_q   <= CDSR_OFF;
      inr_cnt_q <= '0;
    end else if (ce_i) begin
      unique case (phase_q)
        CDSR_OFF: begin
          inr_cnt_q <= '0;
          if (chan_on && !latched_q) begin
            phase_q <= CDSR_INRUSH;
          end
        end
        CDSR_INRUSH: begin
          if (chan_flt) begin
            phase_q <= CDSR_FAULT;
          end else if (!chan_on) begin
            phase_q <= CDSR_OFF;
          end else if (inr_cnt_q >= INR_TICKS[ilim_q[INR_HI:INR_LO]]) begin
            phase_q <= CDSR_STEADY; // RULE_18
          end else if (tick) begin
            inr_cnt_q <= inr_cnt_q + 16'h0001;
          end
        end
        CDSR_STEADY: begin
          if (chan_flt) begin
            phase_q <= CDSR_FAULT;
          end else if (!chan_on) begin
            phase_q <= CDSR_OFF;
          end
        end
        CDSR_FAULT: begin
          // retry waits for the fault to clear unless latched
          if (!chan_flt && !latched_q) begin
            phase_q <= CDSR_OFF; // RULE_13
          end
        end
      endcase
    end
  end

  // latch-off memory: released only by a new switch-state write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latched_q <= 1'b0;
    end else if (ce_i) begin
      if (chan_flt && diag_q[LATCH_BIT]) begin
        latched_q <= 1'b1; // RULE_13
      end else if (sw_edge) begin
        latched_q <= 1'b0; // RULE_13
      end
    end
  end

  // blanking: off-state check must persist before a fault is registered
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blank_cnt_q <= '0;
    end else if (ce_i) begin
      if (!diag_req) begin
        blank_cnt_q <= '0;
      end else if (tick && blank_cnt_q < BLANK_TICKS[diag_q[BLANK_HI:BLANK_LO]]) begin
        blank_cnt_q <= blank_cnt_q + 16'h0001; // RULE_09
      end
    end
  end

  // registered control outputs
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overcurrent_threshold_sel_o <= ILIM_RESET[THR_HI:THR_LO];
      inrush_active_o             <= 1'b0;
      voltage_sense_off_o         <= DIAG_RESET[VSNS_OFF_BIT];
      temp_sense_off_o            <= DIAG_RESET[TSNS_OFF_BIT];
      current_sense_off_o         <= DIAG_RESET[ISNS_OFF_BIT];
      current_sense_gain8_o       <= 1'b0;
      on_openload_precise_en_o    <= 1'b0;
      off_pullup_strength_o       <= 2'h0;
      off_openload_check_en_o     <= 1'b0;
      battery_short_check_en_o    <= 1'b0;
      diag_blank_done_o           <= 1'b0;
      fault_latched_o             <= 1'b0;
      output_slew_sel_o           <= DIAG_RESET[SLEW_HI:SLEW_LO];
    end else if (ce_i) begin
      overcurrent_threshold_sel_o <= ilim_q[THR_HI:THR_LO]; // RULE_01
      inrush_active_o             <= (phase_q == CDSR_INRUSH); // RULE_18
      voltage_sense_off_o         <= diag_q[VSNS_OFF_BIT]; // RULE_03
      temp_sense_off_o            <= diag_q[TSNS_OFF_BIT]; // RULE_04
      current_sense_off_o         <= diag_q[ISNS_OFF_BIT]; // RULE_05
      current_sense_gain8_o       <= diag_q[GAIN8_BIT]; // RULE_07
      on_openload_precise_en_o    <= diag_q[OLPREC_BIT]; // RULE_08
      off_pullup_strength_o       <= diag_q[PU_HI:PU_LO]; // RULE_10
      off_openload_check_en_o     <= diag_q[OLOFF_BIT]; // RULE_11
      battery_short_check_en_o    <= diag_q[SVBB_BIT]; // RULE_12
      diag_blank_done_o           <= diag_req &&
                                     blank_cnt_q >= BLANK_TICKS[diag_q[BLANK_HI:BLANK_LO]];
      fault_latched_o             <= latched_q; // RULE_13
      output_slew_sel_o           <= diag_q[SLEW_HI:SLEW_LO]; // RULE_14
    end
  end

  // result holders; bus writes never reach them
  assign cur_if.wr    = cur_conv_i & ~diag_q[ISNS_OFF_BIT];
  assign cur_if.data  = cur_data_i;
  assign cur_if.rd    = reg_rd_i & (reg_addr_i == ADDR_CUR); // RULE_19
  assign temp_if.wr   = temp_conv_i & ~diag_q[TSNS_OFF_BIT];
  assign temp_if.data = temp_data_i;
  assign temp_if.rd   = reg_rd_i & (reg_addr_i == ADDR_TEMP); // RULE_19

  cdsr_result_reg u_cur (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .res       (cur_if.holder)
  );

  cdsr_result_reg u_temp (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .res       (temp_if.holder)
  );

  // read data registered one cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i && reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_ILIM: reg_rdata_o <= ilim_q;
        ADDR_DIAG: reg_rdata_o <= diag_q; // RULE_06
        ADDR_CUR:  reg_rdata_o <= cur_if.word; // RULE_15 RULE_16
        ADDR_TEMP: reg_rdata_o <= temp_if.word; // RULE_17
        default:   reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  sequence s_diag_wr_on;
    ce_i && reg_wr_i && reg_addr_i == ADDR_DIAG && chan_on;
  endsequence

  AST_OLOFF_BLOCK : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_diag_wr_on |=> !diag_q[OLOFF_BIT] && !diag_q[SVBB_BIT]) // RULE_11
    else $error("off-state check set while channel on");
  AST_PREC_BLOCK : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && reg_wr_i && reg_addr_i == ADDR_DIAG && chan_flt |=> !diag_q[OLPREC_BIT]) // RULE_08
    else $error("precise open-load set under fault");
  AST_THR_OUT : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && reg_wr_i && reg_addr_i == ADDR_ILIM ##1 ce_i |=>
    overcurrent_threshold_sel_o == $past(reg_wdata_i[3:0], 2)) // RULE_01
    else $error("threshold not applied");
  AST_GAIN : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i |=> current_sense_gain8_o == $past(diag_q[GAIN8_BIT])) // RULE_07
    else $error("gain select mismatch");
  AST_LATCH : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    latched_q && !sw_edge && ce_i |=> latched_q) // RULE_13
    else $error("latch released without switch write");
  AST_RES_RO : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    reg_wr_i && reg_addr_i == ADDR_CUR && !cur_if.wr |=> $stable(cur_if.word[9:0])) // RULE_19
    else $error("write altered result");
  AST_RES_ZERO : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cur_if.word[15:11] == 5'h00 && temp_if.word[15:11] == 5'h00) // RULE_15
    else $error("reserved result bits set");
  AST_CLR : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && temp_if.rd && !temp_if.wr |=> !temp_if.word[FRESH_BIT]) // RULE_16
    else $error("read did not clear fresh");
endmodule

// file: cdsr_res_if.sv
`timescale 1ns/1ps
// carries one conversion result and its read-clear between modules
interface cdsr_res_if;
  logic             wr;     // new conversion strobe
  logic [9:0]       data;   // new conversion value
  logic             rd;     // host read of this register
  logic [15:0]      word;   // register image
  modport holder (input wr, input data, input rd, output word);
  modport user   (output wr, output data, output rd, input word);
endinterface

// file: cdsr_result_reg.sv
`timescale 1ns/1ps
// one result register with freshness flag
module cdsr_result_reg
  import cdsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // result link
  cdsr_res_if.holder       res
);
  logic [RES_W-1:0] val_q;  // held conversion
  logic             fresh_q;

  // value updates only on a conversion; host writes never reach here
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      val_q <= '0; // RULE_17
    end else if (ce_i && res.wr) begin
      val_q <= res.data; // RULE_15
    end
  end

  // new data wins over a read in the same cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fresh_q <= 1'b0;
    end else if (ce_i) begin
      if (res.wr) begin
        fresh_q <= 1'b1; // RULE_16
      end else if (res.rd) begin
        fresh_q <= 1'b0; // RULE_19
      end
    end
  end

  assign res.word = {5'h00, fresh_q, val_q}; // RULE_15

  AST_FRESH_SET : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_i && res.wr |=> fresh_q && val_q == $past(res.data)) // RULE_16
    else $error("fresh flag or value not taken");
endmodule

// file: ch2_diag_sense_regs_bench.sv
`timescale 1ns/1ps
// self-checking bench for the channel-2 register bank
module ch2_diag_sense_regs_bench;
  import cdsr_pkg::*;
  logic        clk_sys_i, arst_n_i;
  logic        reg_wr, reg_rd, chan_on, fault, cur_hi, sw_wr;
  logic        cur_conv, temp_conv;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, rdata, r;
  logic [9:0]  cur_data, temp_data, d;
  logic [3:0]  thr;
  logic [1:0]  pu, slew;
  logic        inrush, v_off, t_off, i_off, gain8, prec, ol_off, svbb, blank, latched;
  int          n_errors, samples_checked, cycles;
  logic [15:0] w;
  // clock, 5 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  cdsr_regs dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(rdata), .chan_on_i(chan_on), .chan_fault_i(fault),
    .current_high_i(cur_hi), .switch_state_wr_i(sw_wr), .cur_conv_i(cur_conv),
    .cur_data_i(cur_data), .temp_conv_i(temp_conv), .temp_data_i(temp_data),
    .overcurrent_threshold_sel_o(thr), .inrush_active_o(inrush),
    .voltage_sense_off_o(v_off), .temp_sense_off_o(t_off), .current_sense_off_o(i_off),
    .current_sense_gain8_o(gain8), .on_openload_precise_en_o(prec),
    .off_pullup_strength_o(pu), .off_openload_check_en_o(ol_off),
    .battery_short_check_en_o(svbb), .diag_blank_done_o(blank),
    .fault_latched_o(latched), .output_slew_sel_o(slew));
  cdsr_host_model host (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(rdata));
  // expected control outputs from a diagnostic word
  function automatic logic [15:0] exp_outs(input logic [15:0] x);
    return {4'h0, x[15], x[14], x[13], x[10], x[9], x[6:5], x[4], x[3], x[1:0]};
  endfunction
  // expected threshold after the host clamp
  function automatic logic [15:0] exp_ilim(input logic [15:0] x);
    return (x[3:0] > 4'hC) ? {x[15:4], 4'hC} : x;
  endfunction
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // let n edges pass, then sample settled values
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // one conversion pulse on current (0) or temperature (1)
  task automatic conv(input int k, input logic [9:0] v);
    @(posedge clk_sys_i);
    if (k == 0) begin
      cur_conv <= 1'b1;
      cur_data <= v;
    end else begin
      temp_conv <= 1'b1;
      temp_data <= v;
    end
    @(posedge clk_sys_i);
    cur_conv  <= 1'b0;
    temp_conv <= 1'b0;
    settle(2);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("ERROR %0t: timeout", $time);
      conclude();
    end
  end
  initial begin
    {arst_n_i, chan_on, fault, cur_hi, sw_wr, cur_conv, temp_conv} = '0;
    cur_data  = 10'h000;
    temp_data = 10'h000;
    void'($urandom(32'hBC6F));
    settle(5);
    arst_n_i <= 1'b1;
    settle(1);
    // reset values of registers and controls
    host.read(ADDR_DIAG, r);
    check(r, DIAG_RESET);
    host.read(ADDR_ILIM, r);
    check(r, ILIM_RESET);
    check({12'h0, thr}, 16'h0008);
    check(exp_outs(DIAG_RESET), {4'h0, v_off, t_off, i_off, gain8, prec, pu, ol_off, svbb, slew});
    host.read(ADDR_CUR, r);
    check(r, 16'h0000);
    host.read(ADDR_TEMP, r);
    check(r, 16'h0000);
    $display("test reset done");
    // random configuration words, all-ones corner first
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      host.write(ADDR_DIAG, w);
      host.read(ADDR_DIAG, r);
      check(r, w);
      check({4'h0, v_off, t_off, i_off, gain8, prec, pu, ol_off, svbb, slew}, exp_outs(w));
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      host.write(ADDR_ILIM, w);
      host.read(ADDR_ILIM, r);
      w = exp_ilim(w);
      check(r, w);
      check({12'h0, thr}, {12'h0, w[3:0]});
    end
    $display("test config done");
    // checks refused under fault, channel on, high current
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys_i);
      fault  <= (k == 0);
      chan_on <= (k == 1);
      cur_hi <= (k == 2);
      settle(4);
      host.write(ADDR_DIAG, 16'hFFFF);
      host.read(ADDR_DIAG, r);
      check(r, (k == 0) ? 16'hFDE7 : (k == 1) ? 16'hFFE7 : 16'hFDFF);
      @(posedge clk_sys_i);
      {fault, chan_on, cur_hi} <= 3'b000;
      settle(4);
    end
    $display("test refusal done");
    // results: fresh flag, read clear, writes ignored, sense off
    host.write(ADDR_DIAG, 16'h0002);
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 10'h3FF : 10'($urandom);
      conv(k, d);
      host.read((k == 0) ? ADDR_CUR : ADDR_TEMP, r);
      check(r, {5'h00, 1'b1, d});
      host.read((k == 0) ? ADDR_CUR : ADDR_TEMP, r);
      check(r, {6'h00, d});
      host.write((k == 0) ? ADDR_CUR : ADDR_TEMP, 16'hFFFF);
      host.read((k == 0) ? ADDR_CUR : ADDR_TEMP, r);
      check(r, {6'h00, d});
    end
    host.write(ADDR_DIAG, 16'h6002);
    conv(0, 10'h155);
    host.read(ADDR_CUR, r);
    check(r, {6'h00, 10'h3FF});
    host.read(8'h1B, r);
    check(r, 16'h0000);
    $display("test results done");
    // fault latch versus auto retry; 2 ms inrush keeps the inrush phase up
    host.write(ADDR_ILIM, 16'h0188);
    for (int l = 0; l < 2; l++) begin
      host.write(ADDR_DIAG, l ? 16'h0006 : 16'h0002);
      // earlier faults may have latched the channel; release it first
      @(posedge clk_sys_i);
      sw_wr <= 1'b1;
      settle(4);
      sw_wr <= 1'b0;
      settle(4);
      @(posedge clk_sys_i);
      chan_on <= 1'b1;
      settle(6);
      check({15'h0, inrush}, 16'h0001);
      fault <= 1'b1;
      settle(4);
      fault <= 1'b0;
      settle(8);
      check({15'h0, latched}, {15'h0, 1'(l)});
      @(posedge clk_sys_i);
      sw_wr <= 1'b1;
      settle(4);
      sw_wr <= 1'b0;
      chan_on <= 1'b0;
      settle(6);
      check({15'h0, latched}, 16'h0000);
    end
    $display("test latch done");
    conclude();
  end
endmodule
